// ### hw/psc_cfg_top.sv
// psc_cfg_top: write-only configuration bank of a fractional-N synthesizer,
// registers zero to four, loaded over a three-wire serial link.
// assumes: link pins synchronous to ref_clk; register 6 divider select and
// register 13 high parts arrive as ports from neighbouring banks.
`timescale 1ns/1ps
`include "psc_params.svh"

module psc_cfg_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // three-wire serial link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // reference input
  input wire logic ref_in,
  // fields held by neighbouring banks
  input wire logic [13:0] aux_frac_high_part,
  input wire logic [13:0] aux_modulus_high_part,
  input wire logic [2:0] out_div_sel_in,
  // configuration and events
  output psc_pkg::psc_cfg_s cfg,
  output logic vco_auto_calibration_r,
  output logic mod_reset_r,
  output logic phase_step_r,
  output logic int_range_err_r,
  output logic pfd_tick
);

  logic rst_s1_r;
  logic rst_n_r;
  logic word_vld;
  logic [31:0] word;
  logic [31:0] regs_r [`PSC_NUM_REGS];
  logic [3:0] sel_w;
  logic wr0_w;
  logic wr3_w;
  logic [15:0] int_w;
  logic [15:0] nmin_w;

  logic [15:0] int_div_r;
  logic presc_r;
  logic ac_en_r;
  logic [23:0] main_frac_numerator_r;
  logic [27:0] aux_frac_r;
  logic [27:0] aux_mod_r;
  logic [23:0] phase_out_r;
  logic [2:0] mux_r;
  logic rd2_r;
  logic ref_halver_enable_r;
  logic [9:0] rcnt_r;
  logic [2:0] odiv_r;

  // reset is released through two flops; everything else uses rst_n_r
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  psc_shift u_shift (
    .clk(ref_clk),
    .rst_n(rst_n_r),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .word_vld_r(word_vld),
    .word_r(word)
  );

  assign sel_w = word[`PSC_SEL_MSB:`PSC_SEL_LSB];
  assign wr0_w = word_vld && (sel_w == `PSC_SEL_R0);
  assign wr3_w = word_vld && (sel_w == `PSC_SEL_R3);
  assign int_w = word[`PSC_INT_MSB:`PSC_INT_LSB];
  assign nmin_w = word[`PSC_PR_BIT] ? `PSC_NMIN_89 : `PSC_NMIN_45;

  // raw word store; selects above four belong to other banks and are ignored
  for (genvar i = 0; i < `PSC_NUM_REGS; i++) begin : g_reg
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r)
        regs_r[i] <= `PSC_REG_RST;
      else if (word_vld && (sel_w == 4'(i)))
        regs_r[i] <= word;
    end
  end

  // integer divide and prescaler take effect at once
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      int_div_r <= 16'h0000;
      presc_r <= 1'b0;
      ac_en_r <= 1'b0;
    end else if (wr0_w) begin
      int_div_r <= int_w;
      presc_r <= word[`PSC_PR_BIT];
      ac_en_r <= word[`PSC_AC_BIT];
    end
  end

  // flags an integer value outside the prescaler's legal span
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      int_range_err_r <= 1'b0;
    else if (wr0_w)
      int_range_err_r <= (int_w < nmin_w) ||
        (!word[`PSC_PR_BIT] && int_w > `PSC_NMAX_45);
  end

  // one-cycle events from a register zero write
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      vco_auto_calibration_r <= 1'b0;
      mod_reset_r <= 1'b0;
      phase_step_r <= 1'b0;
    end else begin
      vco_auto_calibration_r <= wr0_w && word[`PSC_AC_BIT];
      mod_reset_r <= wr0_w && !regs_r[3][`PSC_SD_BIT];
      phase_step_r <= wr0_w && regs_r[3][`PSC_PA_BIT];
    end
  end

  // shadowed fields: the main fraction and reference setup wait for the
  // next register zero write so a retune lands as one step
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      main_frac_numerator_r <= 24'h000000;
      rd2_r <= 1'b0;
      ref_halver_enable_r <= 1'b0;
      rcnt_r <= `PSC_RCNT_ONE;
    end else if (wr0_w) begin
      main_frac_numerator_r <= regs_r[1][`PSC_MAIN_FRAC_NUMERATOR_MSB:`PSC_MAIN_FRAC_NUMERATOR_LSB];
      rd2_r <= regs_r[4][`PSC_RD2_BIT];
      ref_halver_enable_r <= regs_r[4][`PSC_REF_HALVER_ENABLE_BIT];
      rcnt_r <= regs_r[4][`PSC_RCNT_MSB:`PSC_RCNT_LSB];
    end
  end

  // mux select is not buffered so a host can switch it after lock
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      mux_r <= 3'h0;
    else if (word_vld && sel_w == `PSC_SEL_R4)
      mux_r <= word[`PSC_MUX_MSB:`PSC_MUX_LSB];
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      odiv_r <= 3'h0;
    else if (!regs_r[4][`PSC_D1_BIT] || wr0_w)
      odiv_r <= out_div_sel_in;
  end

  // wide aux values are rebuilt every cycle from both halves
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aux_frac_r <= 28'h0000000;
      aux_mod_r <= 28'h0000000;
    end else begin
      aux_frac_r <= 28'((28'(aux_frac_high_part) << `PSC_AUX_SHIFT) +
        28'(regs_r[2][`PSC_F2LO_MSB:`PSC_F2LO_LSB]));
      aux_mod_r <= 28'((28'(aux_modulus_high_part) << `PSC_AUX_SHIFT) +
        28'(regs_r[2][`PSC_M2LO_MSB:`PSC_M2LO_LSB]));
    end
  end

  // a phase write sets the phase; adjust mode then accumulates it
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r)
      phase_out_r <= 24'h000000;
    else if (wr3_w)
      phase_out_r <= word[`PSC_PH_MSB:`PSC_PH_LSB];
    else if (wr0_w && regs_r[3][`PSC_PA_BIT])
      phase_out_r <= phase_out_r +
        regs_r[3][`PSC_PH_MSB:`PSC_PH_LSB];
  end

  psc_ref_div u_ref_div (
    .clk(ref_clk),
    .rst_n(rst_n_r),
    .ref_in(ref_in),
    .dbl_en(rd2_r),
    .half_en(ref_halver_enable_r),
    .r_div(rcnt_r),
    .pfd_tick_r(pfd_tick)
  );

  assign cfg.int_divide = int_div_r;
  assign cfg.prescaler_89 = presc_r;
  assign cfg.vco_auto_calibration_enable = ac_en_r;
  assign cfg.main_frac_numerator = main_frac_numerator_r;
  assign cfg.aux_frac_numerator = aux_frac_r;
  assign cfg.aux_modulus = aux_mod_r;
  assign cfg.modulator_reset_disable = regs_r[3][`PSC_SD_BIT];
  assign cfg.resync_enable = regs_r[3][`PSC_RESYNC_BIT];
  assign cfg.phase_adjust_enable = regs_r[3][`PSC_PA_BIT];
  assign cfg.phase_value_field = regs_r[3][`PSC_PH_MSB:`PSC_PH_LSB];
  assign cfg.output_phase = phase_out_r;
  assign cfg.test_mux_select = mux_r;
  assign cfg.ref_doubler_enable = rd2_r;
  assign cfg.ref_halver_enable = ref_halver_enable_r;
  assign cfg.r_counter = rcnt_r;
  assign cfg.double_buffer_enable = regs_r[4][`PSC_D1_BIT];
  assign cfg.out_div_select = odiv_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  route_one_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R1) |=> regs_r[1] == $past(word))
    else $error("register one word not stored");

  route_four_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R4) |=>
      regs_r[4] == $past(word) && regs_r[3] == $past(regs_r[3]))
    else $error("register four word misrouted");

  cal_start_a: assert property (
    wr0_w |=> vco_auto_calibration_r == $past(word[`PSC_AC_BIT])
      ##1 !vco_auto_calibration_r)
    else $error("calibration pulse wrong");

  range_flag_a: assert property (
    (wr0_w && word[`PSC_PR_BIT] && int_w < `PSC_NMIN_89) |=>
      int_range_err_r)
    else $error("8/9 minimum not flagged");

  sd_reset_a: assert property (
    mod_reset_r |-> $past(wr0_w) && !regs_r[3][`PSC_SD_BIT])
    else $error("modulator reset without cause");

  phase_step_a: assert property (
    (wr0_w && regs_r[3][`PSC_PA_BIT]) |=>
      phase_out_r == 24'($past(phase_out_r) +
        $past(regs_r[3][`PSC_PH_MSB:`PSC_PH_LSB])) && phase_step_r)
    else $error("phase not advanced");

  shadow_hold_a: assert property (
    !wr0_w |=> $stable(main_frac_numerator_r) && $stable(rcnt_r))
    else $error("shadowed field moved early");

  shadow_load_a: assert property (
    wr0_w |=> main_frac_numerator_r == $past(regs_r[1][`PSC_MAIN_FRAC_NUMERATOR_MSB:`PSC_MAIN_FRAC_NUMERATOR_LSB]))
    else $error("main fraction not applied");

  odiv_hold_a: assert property (
    (regs_r[4][`PSC_D1_BIT] && !wr0_w) |=> $stable(odiv_r))
    else $error("buffered divider select moved");

  mux_sel_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R4) |=>
      mux_r == $past(word[`PSC_MUX_MSB:`PSC_MUX_LSB]))
    else $error("mux select not loaded");

  aux_build_a: assert property (
    rst_n_r |=>
      aux_frac_r[13:0] == $past(regs_r[2][`PSC_F2LO_MSB:`PSC_F2LO_LSB])
      && aux_frac_r[27:14] == $past(aux_frac_high_part))
    else $error("aux numerator halves misplaced");

  route_zero_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R0) |=> regs_r[0] == $past(word))
    else $error("register zero word not stored");

  route_two_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R2) |=> regs_r[2] == $past(word))
    else $error("register two word not stored");

  route_three_a: assert property (
    (word_vld && sel_w == `PSC_SEL_R3) |=> regs_r[3] == $past(word))
    else $error("register three word not stored");

  // selects above four belong to other banks and must leave registers zero, one and four alone
  foreign_drop_a: assert property (
    (word_vld && sel_w > `PSC_SEL_R4) |=>
      regs_r[0] == $past(regs_r[0]) && regs_r[1] == $past(regs_r[1])
      && regs_r[4] == $past(regs_r[4]))
    else $error("foreign word changed the bank");

  int_load_a: assert property (
    wr0_w |=> int_div_r == $past(int_w) &&
      presc_r == $past(word[`PSC_PR_BIT]))
    else $error("integer divide or prescaler not loaded");

  cal_quiet_a: assert property (
    !wr0_w |=> !vco_auto_calibration_r)
    else $error("calibration pulse without register zero write");

  range_max_a: assert property (
    (wr0_w && !word[`PSC_PR_BIT] && int_w > `PSC_NMAX_45) |=>
      int_range_err_r)
    else $error("4/5 maximum not flagged");

  range_ok_a: assert property (
    (wr0_w && word[`PSC_PR_BIT] && int_w >= `PSC_NMIN_89) |=>
      !int_range_err_r)
    else $error("legal 8/9 value flagged");

  sd_hold_a: assert property (
    (wr0_w && regs_r[3][`PSC_SD_BIT]) |=> !mod_reset_r)
    else $error("modulator reset while disabled");

  phase_load_a: assert property (
    wr3_w |=> phase_out_r == $past(word[`PSC_PH_MSB:`PSC_PH_LSB]))
    else $error("phase value not loaded");

  phase_quiet_a: assert property (
    (wr0_w && !regs_r[3][`PSC_PA_BIT]) |=>
      !phase_step_r && $stable(phase_out_r))
    else $error("phase moved with adjust off");

  shadow_ref_a: assert property (
    wr0_w |=> rcnt_r == $past(regs_r[4][`PSC_RCNT_MSB:`PSC_RCNT_LSB])
      && rd2_r == $past(regs_r[4][`PSC_RD2_BIT])
      && ref_halver_enable_r == $past(regs_r[4][`PSC_REF_HALVER_ENABLE_BIT]))
    else $error("reference setup not applied");

  // the reset term keeps the first attempt after release from seeing
  // flops that were still held in reset at that edge
  odiv_follow_a: assert property (
    (rst_n_r && !regs_r[4][`PSC_D1_BIT]) |=>
      odiv_r == $past(out_div_sel_in))
    else $error("unbuffered divider select lagging");

  aux_mod_a: assert property (
    rst_n_r |=>
      aux_mod_r[13:0] == $past(regs_r[2][`PSC_M2LO_MSB:`PSC_M2LO_LSB])
      && aux_mod_r[27:14] == $past(aux_modulus_high_part))
    else $error("aux modulus halves misplaced");

endmodule : psc_cfg_top

// ### hw/psc_params.svh
// psc_params.svh: offsets, field positions, reset values and counts for the
// synthesizer configuration bank.
// assumes: included by its bare name; holds definitions only.
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

`define PSC_WORD_BITS 32
`define PSC_CNT_W 6
`define PSC_SEL_MSB 3
`define PSC_SEL_LSB 0
`define PSC_SEL_R0 4'h0
`define PSC_SEL_R1 4'h1
`define PSC_SEL_R2 4'h2
`define PSC_SEL_R3 4'h3
`define PSC_SEL_R4 4'h4
`define PSC_NUM_REGS 5
`define PSC_REG_RST 32'h00000000

`define PSC_AC_BIT 21
`define PSC_PR_BIT 20
`define PSC_INT_MSB 19
`define PSC_INT_LSB 4
`define PSC_NMIN_45 16'h0017
`define PSC_NMIN_89 16'h004B
`define PSC_NMAX_45 16'h7FFF

`define PSC_MAIN_FRAC_NUMERATOR_MSB 27
`define PSC_MAIN_FRAC_NUMERATOR_LSB 4
`define PSC_F2LO_MSB 31
`define PSC_F2LO_LSB 18
`define PSC_M2LO_MSB 17
`define PSC_M2LO_LSB 4
`define PSC_AUX_SHIFT 14

`define PSC_SD_BIT 30
`define PSC_RESYNC_BIT 29
`define PSC_PA_BIT 28
`define PSC_PH_MSB 27
`define PSC_PH_LSB 4

`define PSC_MUX_MSB 29
`define PSC_MUX_LSB 27
`define PSC_RD2_BIT 26
`define PSC_REF_HALVER_ENABLE_BIT 25
`define PSC_RCNT_MSB 24
`define PSC_RCNT_LSB 15
`define PSC_D1_BIT 14
`define PSC_RCNT_ONE 10'h001

`endif

// ### hw/psc_pkg.sv
// psc_pkg: types shared by the configuration bank and its helpers.
// assumes: psc_params.svh is on the include path.
`include "psc_params.svh"

package psc_pkg;

  typedef enum logic [3:0] {
    PSC_REG0 = `PSC_SEL_R0,
    PSC_REG1 = `PSC_SEL_R1,
    PSC_REG2 = `PSC_SEL_R2,
    PSC_REG3 = `PSC_SEL_R3,
    PSC_REG4 = `PSC_SEL_R4
  } psc_reg_e;

  typedef struct packed {
    logic [15:0] int_divide;
    logic prescaler_89;
    logic vco_auto_calibration_enable;
    logic [23:0] main_frac_numerator;
    logic [27:0] aux_frac_numerator;
    logic [27:0] aux_modulus;
    logic modulator_reset_disable;
    logic resync_enable;
    logic phase_adjust_enable;
    logic [23:0] phase_value_field;
    logic [23:0] output_phase;
    logic [2:0] test_mux_select;
    logic ref_doubler_enable;
    logic ref_halver_enable;
    logic [9:0] r_counter;
    logic double_buffer_enable;
    logic [2:0] out_div_select;
  } psc_cfg_s;

endpackage : psc_pkg

// ### hw/psc_shift.sv
// psc_shift: three-wire receiver, collects a 32-bit word msb first.
// assumes: link pins already synchronous to clk; rst_n is a synced reset.
`timescale 1ns/1ps
`include "psc_params.svh"

module psc_shift (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // received word
  output logic word_vld_r,
  output logic [31:0] word_r
);

  logic sclk_d_r;
  logic le_d_r;
  logic [31:0] shift_r;
  logic [`PSC_CNT_W-1:0] cnt_r;
  logic full_w;

  assign full_w = (cnt_r == `PSC_CNT_W'(`PSC_WORD_BITS));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      // strobe idles high, so a low reset copy would see a false rise
      le_d_r <= 1'b1;
    end else begin
      sclk_d_r <= ser_clk;
      le_d_r <= ser_le;
    end
  end

  // count saturates above 32 so an overlong word is also discarded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= `PSC_REG_RST;
      cnt_r <= '0;
    end else if (ser_le && !le_d_r) begin
      cnt_r <= '0;
    end else if (ser_clk && !sclk_d_r && !ser_le) begin
      shift_r <= {shift_r[30:0], ser_data};
      if (cnt_r <= `PSC_CNT_W'(`PSC_WORD_BITS))
        cnt_r <= cnt_r + `PSC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_vld_r <= 1'b0;
      word_r <= `PSC_REG_RST;
    end else begin
      word_vld_r <= ser_le && !le_d_r && full_w;
      if (ser_le && !le_d_r && full_w)
        word_r <= shift_r;
    end
  end

  partial_drop_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ser_le && !le_d_r && !full_w) |=> !word_vld_r)
    else $error("partial word was accepted");

endmodule : psc_shift

// ### hw/psc_ref_div.sv
// psc_ref_div: reference path model, doubler, R counter and halver,
// producing one-cycle phase detector ticks.
// assumes: ref_in is sampled by clk and much slower than it.
`timescale 1ns/1ps

module psc_ref_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reference and settings
  input wire logic ref_in,
  input wire logic dbl_en,
  input wire logic half_en,
  input wire logic [9:0] r_div,
  // phase detector tick
  output logic pfd_tick_r
);

  logic ref_d_r;
  logic [9:0] cnt_r;
  logic tog_r;
  logic edge_w;
  logic wrap_w;
  logic [9:0] ratio_w;

  // single edge is the falling one; doubler makes both edges count
  assign edge_w = dbl_en ? (ref_in ^ ref_d_r) : (ref_d_r && !ref_in);
  // ratio zero is illegal; treat it as one rather than stall
  assign ratio_w = (r_div == 10'h000) ? 10'h001 : r_div;
  assign wrap_w = edge_w && (cnt_r + 10'h001 >= ratio_w);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r <= 1'b0;
      cnt_r <= 10'h000;
    end else begin
      ref_d_r <= ref_in;
      if (wrap_w)
        cnt_r <= 10'h000;
      else if (edge_w)
        cnt_r <= cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_r <= 1'b0;
      pfd_tick_r <= 1'b0;
    end else begin
      if (wrap_w)
        tog_r <= !tog_r;
      pfd_tick_r <= wrap_w && (!half_en || !tog_r);
    end
  end

endmodule : psc_ref_div

// ### dv/psc_host_model.sv
// psc_host_model: host side of the three-wire link, shifts words msb first.
// assumes: ref_clk is the bench clock; caller waits out the reset release.
`timescale 1ns/1ps

module psc_host_model (
  // clock
  input wire logic ref_clk,
  // three-wire link
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b1;
  end

  // sends the top n bits of w; n other than 32 makes a broken word
  task automatic send(input logic [31:0] w, input int n);
    int i;
    @(posedge ref_clk) #1 ser_le = 1'b0;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk) #1 ser_clk = 1'b0;
      ser_data = w[31-i];
      @(posedge ref_clk) #1 ser_clk = 1'b1;
    end
    @(posedge ref_clk) #1 ser_clk = 1'b0;
    // released data shows the inverse so a stale bit is never trusted
    ser_data = ~ser_data;
    @(posedge ref_clk) #1 ser_le = 1'b1;
  endtask : send
endmodule : psc_host_model

// ### dv/psc_cfg_top_test.sv
// psc_cfg_top_test: self-checking bench for the configuration bank.
// assumes: design under hw/, host model in dv/psc_host_model.sv.
`timescale 1ns/1ps

module psc_cfg_top_test;
  logic ref_clk, rst_b, ser_clk, ser_data, ser_le, ref_in;
  logic cal, mrst, pstep, ierr, tick, pr, ac, sd, pa, d1, p_rd2, p_rdv;
  logic [13:0] fhi, mhi, flo, mlo;
  logic [2:0] odiv_in, o;
  logic [15:0] seed, nv;
  logic [23:0] e_ph, e_pv, p_fr;
  logic [9:0] p_r;
  logic [16:0] corner [7];
  logic [11:0] pfd_tab [5];
  psc_pkg::psc_cfg_s cfg, rst_cfg;
  int n_fail, checks, n_cal, n_mr, n_ps, n_tk, i, e;

  psc_cfg_top dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_le(ser_le), .ref_in(ref_in),
    .aux_frac_high_part(fhi), .aux_modulus_high_part(mhi),
    .out_div_sel_in(odiv_in), .cfg(cfg), .vco_auto_calibration_r(cal),
    .mod_reset_r(mrst), .phase_step_r(pstep), .int_range_err_r(ierr),
    .pfd_tick(tick)
  );

  psc_host_model host_u (
    .ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le)
  );

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  function automatic logic [23:0] r24();
    logic [31:0] t;
    t = {rnd(), rnd()};
    return t[23:0];
  endfunction : r24

  function automatic logic [31:0] w0(logic [15:0] n, logic p, logic a);
    return {10'h000, a, p, n, 4'h0};
  endfunction : w0

  function automatic logic [31:0] w3(logic s, logic r, logic a,
                                     logic [23:0] ph);
    return {1'b0, s, r, a, ph, 4'h3};
  endfunction : w3

  function automatic logic [31:0] w4(logic [2:0] m, logic d, logic h,
                                     logic [9:0] r, logic b);
    return {2'b00, m, d, h, r, b, 10'h000, 4'h4};
  endfunction : w4

  function automatic logic exp_err(logic [15:0] n, logic p);
    return p ? (n < 16'h004B) : (n < 16'h0017 || n > 16'h7FFF);
  endfunction : exp_err

  function automatic logic [27:0] aux(logic [13:0] hi, logic [13:0] lo);
    return ({14'h0000, hi} << 14) + {14'h0000, lo};
  endfunction : aux

  task automatic chk(input logic [167:0] got, input logic [167:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // counts each pulse over the window that holds its answer
  task automatic wr(input logic [31:0] w, input int n);
    host_u.send(w, n);
    n_cal = 0;
    n_mr = 0;
    n_ps = 0;
    repeat (6) begin
      @(posedge ref_clk) #1;
      n_cal += (cal === 1'b1);
      n_mr += (mrst === 1'b1);
      n_ps += (pstep === 1'b1);
    end
  endtask : wr

  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // reference toggles every 3 cycles: 100 falling edges per 600 cycles
  initial begin
    ref_in = 1'b0;
    forever begin
      repeat (3) @(posedge ref_clk);
      #1 ref_in = ~ref_in;
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    fhi = 14'h0000;
    mhi = 14'h0000;
    odiv_in = 3'h0;
    n_fail = 0;
    checks = 0;
    seed = 16'h8581; // 34177
    corner = '{17'h00017, 17'h07FFF, 17'h00016, 17'h08000, 17'h1004B,
               17'h1FFFF, 17'h1004A};
    pfd_tab = '{12'h00C, 12'h006, 12'h009, 12'h000, 12'h013};
    rst_cfg = '0;
    rst_cfg.r_counter = 10'h001;
    repeat (12) @(posedge ref_clk);
    #1 chk(cfg, rst_cfg);
    chk({cal, mrst, pstep, ierr, tick}, 5'h00);
    rst_b = 1'b1;
    repeat (4) @(posedge ref_clk);
    // a foreign selector and a short word must both leave the bank alone
    wr(w0(16'h1234, 1'b0, 1'b1) | 32'h5, 32);
    chk({cfg.int_divide, n_cal + n_mr + n_ps}, 0);
    wr(w0(16'h0100, 1'b0, 1'b1), 31);
    chk({cfg.int_divide, n_cal + n_mr + n_ps}, 0);
    e_pv = r24();
    wr(w3(1'b0, 1'b1, 1'b0, e_pv), 32);
    chk({cfg.phase_value_field, cfg.output_phase}, {e_pv, e_pv});
    chk({cfg.modulator_reset_disable, cfg.resync_enable}, 2'b01);
    for (i = 0; i < 8; i++) begin
      wr(w4(i[2:0], 1'b1, 1'b1, 10'h3FF, 1'b0), 32);
      chk(cfg.test_mux_select, i[2:0]);
      chk({cfg.r_counter, cfg.ref_doubler_enable}, 11'h002);
    end
    wr({4'h0, r24(), 4'h1}, 32);
    chk(cfg.main_frac_numerator, 0);
    mhi = 14'(rnd()) | 14'h2000;
    fhi = mhi >> 1;
    flo = 14'(rnd());
    mlo = 14'(rnd());
    wr({flo, mlo, 4'h2}, 32);
    chk(cfg.aux_frac_numerator, aux(fhi, flo));
    chk(cfg.aux_modulus, aux(mhi, mlo));
    for (i = 0; i < 14; i++) begin
      sd = (i % 3) != 0;
      pa = (i % 3) == 2;
      e_pv = r24();
      wr(w3(sd, 1'b0, pa, e_pv), 32);
      e_ph = e_pv;
      p_fr = r24();
      wr({4'h0, p_fr, 4'h1}, 32);
      p_r = 10'(rnd());
      {p_rd2, p_rdv} = 2'(rnd());
      d1 = i[0];
      wr(w4(3'h0, p_rd2, p_rdv, p_r, d1), 32);
      odiv_in = 3'(rnd());
      {pr, nv} = (i < 7) ? corner[i] : {1'(rnd()), rnd()};
      if (i >= 7 && !pr) nv[15] = 1'b0;
      if (i >= 7 && nv < 16'h004B) nv = 16'h0100;
      ac = pa ? 1'b0 : 1'(rnd());
      wr(w0(nv, pr, ac), 32);
      if (pa) e_ph = e_ph + e_pv;
      chk({cfg.int_divide, cfg.prescaler_89}, {nv, pr});
      chk(ierr, exp_err(nv, pr));
      chk(n_cal, ac);
      chk(n_mr, !sd);
      chk({cfg.vco_auto_calibration_enable, cfg.phase_adjust_enable}, {ac, pa});
      chk(cfg.double_buffer_enable, d1);
      chk({n_ps, cfg.output_phase}, {pa, e_ph});
      chk(cfg.main_frac_numerator, p_fr);
      chk({cfg.r_counter, cfg.ref_doubler_enable, cfg.ref_halver_enable},
          {p_r, p_rd2, p_rdv});
      chk(cfg.out_div_select, odiv_in);
      o = odiv_in;
      odiv_in = ~odiv_in;
      repeat (3) @(posedge ref_clk);
      #1 chk(cfg.out_div_select, d1 ? o : odiv_in);
    end
    for (i = 0; i < 5; i++) begin
      wr(w4(3'h0, pfd_tab[i][1], pfd_tab[i][0], pfd_tab[i][11:2], 1'b0),
         32);
      wr(w0(16'h0100, 1'b0, 1'b0), 32);
      n_tk = 0;
      repeat (600) begin
        @(posedge ref_clk) #1;
        n_tk += (tick === 1'b1);
      end
      e = (pfd_tab[i][1] ? 200 : 100) / (pfd_tab[i][11:2] == 0 ? 1 :
          int'(pfd_tab[i][11:2])) / (pfd_tab[i][0] ? 2 : 1);
      chk(n_tk >= e - 1 && n_tk <= e + 1, 1'b1);
    end
    report_and_stop();
  end
endmodule : psc_cfg_top_test
